// ---- inc/chop_map.svh ----
`ifndef CHOP_MAP_SVH
`define CHOP_MAP_SVH
// Chopping period length in oscillator clocks
`define CHOP_PERIOD_CLKS   5'h10
// Oscillator clock count at whose rising edge fast decay starts
`define CHOP_FAST_START    5'h0b
// Current-limit blanking lengths in oscillator clocks
`define CHOP_BLANK_SHORT   5'h04
`define CHOP_BLANK_LONG    5'h06
// Counter value at reset and at the start of each period
`define CHOP_COUNT_RESET   5'h00
// Register values at reset: bridge switches all off, blanking on
`define CHOP_SW_RESET      4'h0
`define CHOP_BLANK_RESET   1'h1
`endif

// ---- inc/chop_pkg.sv ----
package chop_pkg;
  // Bridge state; binary codes written out
  typedef enum logic [1:0] {
    ST_CHARGE = 2'b00,
    ST_SLOW   = 2'b01,
    ST_FAST   = 2'b10
  } bridge_state_t;

  // Switch drive word: {hs_first, hs_second, ls_first, ls_second}
  typedef logic [3:0] switch_word_t;
endpackage

// ---- inc/chop_tick_if.sv ----
// Oscillator edge events passed from the edge finder to the sequencer
interface chop_tick_if;
  logic rise;
  modport src (output rise);
  modport dst (input  rise);
endinterface

// ---- verilog/chop_edge_detect.sv ----
// Finds rising edges of the chop oscillator clock, sampled on mclk.
// The oscillator is treated as a synchronous input, so no synchroniser.
module chop_edge_detect (
  input  wire logic  mclk,
  input  wire logic  reset_n,
  input  wire logic  chop_oscillator_clock,
  chop_tick_if.src   tick
);
  logic osc_q;

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= chop_oscillator_clock;
    end
  end

  // One mclk pulse per oscillator rising edge
  assign tick.rise = chop_oscillator_clock & ~osc_q;
endmodule // chop_edge_detect

// ---- verilog/chopper_bridge_switch_control.sv ----
`include "chop_map.svh"

// Functional notes
// - Charge: first high and second low switches on, others off.
// - Slow decay: both high switches off, both low switches on.
// - Fast decay: second high and first low on, others off.
// - Only charge, slow decay and fast decay states regulate current.
// - Chopping is timed from the internal chop oscillator clock.
// - One chopping period lasts sixteen oscillator clocks.
// - Charge starts with the counter; current trip moves charge to slow.
// - Slow decay becomes fast decay on rising edge of eleventh clock.
// - After sixteen clocks fast decay ends, counter resets, charge again.
// - Trip detection blanked 4 clocks, or 6 with blanking select high.
module chopper_bridge_switch_control (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic chop_oscillator_clock,
  input  wire logic current_limit_trip,
  input  wire logic blanking_select,
  input  wire logic reverse_dir,
  output logic      high_side_switch_first,
  output logic      high_side_switch_second,
  output logic      low_side_switch_first,
  output logic      low_side_switch_second,
  output logic      detect_blank_active
);
  chop_tick_if tick ();

  chop_pkg::bridge_state_t state_q;
  chop_pkg::bridge_state_t state_d;
  logic [4:0]              count_q;
  logic [4:0]              count_d;
  logic [4:0]              blank_len;
  chop_pkg::switch_word_t  sw_fwd;
  chop_pkg::switch_word_t  sw_d;
  chop_pkg::switch_word_t  sw_q;
  logic                    blank_d;
  logic                    blank_q;
  logic                    period_end;
  logic                    fast_start;
  logic                    trip_seen;

  // Oscillator edges drive all chop timing
  chop_edge_detect u_edge (
    .mclk                  (mclk),
    .reset_n               (reset_n),
    .chop_oscillator_clock (chop_oscillator_clock),
    .tick                  (tick)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Forward switch pattern per state
  function automatic chop_pkg::switch_word_t pattern(
    input chop_pkg::bridge_state_t st);
    case (st)
      chop_pkg::ST_CHARGE: pattern = 4'b1001;
      chop_pkg::ST_SLOW:   pattern = 4'b0011;
      chop_pkg::ST_FAST:   pattern = 4'b0110;
      default:             pattern = 4'b0011;
    endcase
  endfunction

  // Swap first and second in both pairs for reverse current
  function automatic chop_pkg::switch_word_t mirror(
    input chop_pkg::switch_word_t w);
    mirror = {w[2], w[3], w[0], w[1]};
  endfunction

  // ----------------------------------------------------------------
  // Period counter and decode
  // ----------------------------------------------------------------
  // Counter holds the number of oscillator rises seen in this period
  assign period_end = tick.rise &&
                      (count_q == `CHOP_PERIOD_CLKS - 5'h01);
  assign fast_start = tick.rise &&
                      (count_q == `CHOP_FAST_START - 5'h01);
  assign count_d    = period_end ? `CHOP_COUNT_RESET :
                      tick.rise  ? count_q + 5'h01 : count_q;
  assign blank_len  = blanking_select ? `CHOP_BLANK_LONG :
                                        `CHOP_BLANK_SHORT;
  // Blanking covers the first oscillator clocks of each charge period;
  // trips inside it are ignored, so the current may overshoot briefly.
  assign blank_d    = (count_d < blank_len);
  assign trip_seen  = current_limit_trip && !blank_q;

  // ----------------------------------------------------------------
  // Bridge state selection
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      chop_pkg::ST_CHARGE: begin
        if (period_end) begin
          state_d = chop_pkg::ST_CHARGE;
        end else if (fast_start) begin
          state_d = chop_pkg::ST_FAST;
        end else if (trip_seen) begin
          state_d = chop_pkg::ST_SLOW;
        end
      end
      chop_pkg::ST_SLOW: begin
        if (period_end) begin
          state_d = chop_pkg::ST_CHARGE;
        end else if (fast_start) begin
          state_d = chop_pkg::ST_FAST;
        end
      end
      chop_pkg::ST_FAST: begin
        if (period_end) begin
          state_d = chop_pkg::ST_CHARGE;
        end
      end
      default: state_d = chop_pkg::ST_SLOW;
    endcase
  end

  // Output pattern follows the next state, mirrored when reversed
  assign sw_fwd = pattern(state_d);
  assign sw_d   = reverse_dir ? mirror(sw_fwd) : sw_fwd;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset loads charge state at period start with all switches off, as at power-up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= chop_pkg::ST_CHARGE;
      count_q <= `CHOP_COUNT_RESET;
      sw_q    <= `CHOP_SW_RESET;
      blank_q <= `CHOP_BLANK_RESET;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      sw_q    <= sw_d;
      blank_q <= blank_d;
    end
  end

  assign high_side_switch_first  = sw_q[3];
  assign high_side_switch_second = sw_q[2];
  assign low_side_switch_first   = sw_q[1];
  assign low_side_switch_second  = sw_q[0];
  assign detect_blank_active     = blank_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence period_wrap_s;
    tick.rise && count_q == 5'h0f;
  endsequence

  // Last oscillator rise inside each blanking window
  sequence blank_short_end_s;
    tick.rise && count_q == `CHOP_BLANK_SHORT - 5'h01 && !blanking_select;
  endsequence

  sequence blank_long_end_s;
    tick.rise && count_q == `CHOP_BLANK_LONG - 5'h01 && blanking_select;
  endsequence

  // Switches are all off for one cycle after reset, so skip that edge
  charge_pattern_a: assert property (
    state_q == chop_pkg::ST_CHARGE && $past(state_q) == state_q &&
    $past(reset_n) && !$past(reverse_dir) |-> sw_q == 4'b1001)
    else $error("charge switch pattern wrong");
  slow_pattern_a: assert property (
    state_q == chop_pkg::ST_SLOW && $past(state_q) == state_q
    |-> sw_q == 4'b0011)
    else $error("slow decay switch pattern wrong");
  fast_pattern_a: assert property (
    state_q == chop_pkg::ST_FAST && $past(state_q) == state_q &&
    !$past(reverse_dir) |-> sw_q == 4'b0110)
    else $error("fast decay switch pattern wrong");
  legal_state_a: assert property (
    state_q != 2'b11)
    else $error("illegal bridge state");
  count_hold_a: assert property (
    !tick.rise |=> $stable(count_q))
    else $error("counter moved without oscillator edge");
  period_wrap_a: assert property (
    period_wrap_s |=> count_q == 5'h00)
    else $error("period did not wrap at sixteen");
  mirror_charge_a: assert property (
    state_q == chop_pkg::ST_CHARGE && $past(state_q) == state_q &&
    $past(reset_n) && $past(reverse_dir) |-> sw_q == 4'b0110)
    else $error("reverse charge pattern wrong");
  trip_slow_a: assert property (
    state_q == chop_pkg::ST_CHARGE && current_limit_trip && !blank_q &&
    !tick.rise |=> state_q == chop_pkg::ST_SLOW)
    else $error("trip did not enter slow decay");
  fast_entry_a: assert property (
    state_q == chop_pkg::ST_SLOW && tick.rise && count_q == 5'h0a
    |=> state_q == chop_pkg::ST_FAST)
    else $error("fast decay not entered at eleventh clock");
  recharge_a: assert property (
    period_wrap_s |=> state_q == chop_pkg::ST_CHARGE)
    else $error("charge not restarted at period end");
  blank_len_a: assert property (
    blank_short_end_s |=> !blank_q)
    else $error("short blanking too long");
  blank_long_a: assert property (
    blank_long_end_s |=> !blank_q)
    else $error("long blanking length wrong");
  // Past the short length, long blanking must still be on
  blank_hold_a: assert property (
    tick.rise && count_q == `CHOP_BLANK_LONG - 5'h02 && blanking_select
    |=> blank_q)
    else $error("long blanking ended early");
  blank_restart_a: assert property (
    period_wrap_s |=> blank_q)
    else $error("blanking not restarted at period start");
  trip_refused_a: assert property (
    state_q == chop_pkg::ST_CHARGE && blank_q && !tick.rise
    |=> state_q == chop_pkg::ST_CHARGE)
    else $error("trip acted on during blanking");
  slow_hold_a: assert property (
    state_q == chop_pkg::ST_SLOW && !tick.rise
    |=> state_q == chop_pkg::ST_SLOW)
    else $error("slow decay left between oscillator edges");
  fast_hold_a: assert property (
    state_q == chop_pkg::ST_FAST && !tick.rise
    |=> state_q == chop_pkg::ST_FAST)
    else $error("fast decay left before period end");
endmodule // chopper_bridge_switch_control

// ---- tb/bridge_motor_model.sv ----
// ----------------------------------------
// Winding current model behind the bridge
// ----------------------------------------
module bridge_motor_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       hs_first,
  input  wire logic       hs_second,
  input  wire logic       ls_first,
  input  wire logic       ls_second,
  input  wire logic       dir_rev,
  input  wire logic       slow_mode,
  input  wire logic [7:0] limit,
  output logic            trip
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cur_q;
  logic [1:0] div_q;
  // Drive direction decides which diagonal pushes current up
  wire charging = dir_rev ? (hs_second & ls_first) : (hs_first & ls_second);
  // Slow mode lets current move only every fourth cycle
  wire step     = !slow_mode || (div_q == 2'h3);
  // Current rises while charging and sinks toward zero otherwise
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= 8'h00;
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (step && charging && cur_q != 8'hff) cur_q <= cur_q + 8'h01;
      else if (step && !charging && cur_q != 8'h00) cur_q <= cur_q - 8'h01;
    end
  end
  assign trip = (cur_q >= limit);
endmodule // bridge_motor_model

// ---- tb/chopper_bridge_switch_control_test.sv ----
module chopper_bridge_switch_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk = 1'b0, reset_n = 1'b0, osc = 1'b0;
  logic       bsel = 1'b0, rev = 1'b0, slow = 1'b0;
  logic [7:0] limit = 8'hff;
  logic       hs1, hs2, ls1, ls2, blank, trip;
  int         bad_count = 0, samples_checked = 0, cycles = 0;
  always #2 mclk = ~mclk;
  chopper_bridge_switch_control DUT (.mclk(mclk), .reset_n(reset_n),
    .chop_oscillator_clock(osc), .current_limit_trip(trip),
    .blanking_select(bsel), .reverse_dir(rev),
    .high_side_switch_first(hs1), .high_side_switch_second(hs2),
    .low_side_switch_first(ls1), .low_side_switch_second(ls2),
    .detect_blank_active(blank));
  bridge_motor_model motor (.mclk(mclk), .reset_n(reset_n),
    .hs_first(hs1), .hs_second(hs2), .ls_first(ls1), .ls_second(ls2),
    .dir_rev(rev), .slow_mode(slow), .limit(limit), .trip(trip));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hung scenario must not stall the run forever; 2000 cycles fail the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [4:0] seen, logic [4:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected switch word {hs1,hs2,ls1,ls2}; reverse swaps each pair
  function automatic chop_pkg::switch_word_t word(
      chop_pkg::bridge_state_t st, logic r);
    case (st)
      chop_pkg::ST_CHARGE: return r ? 4'h6 : 4'h9;
      chop_pkg::ST_SLOW:   return 4'h3;
      default:             return r ? 4'h9 : 4'h6;
    endcase
  endfunction
  // One oscillator rise; seven cycles leave room for the pipeline
  task automatic rise();
    @(posedge mclk); #1 osc = 1'b1;
    repeat (3) @(posedge mclk);
    #1 osc = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Sixteen rises from count zero, judged after every rise
  task automatic period(int blen, bit tripped);
    chop_pkg::bridge_state_t st;
    for (int n = 1; n <= 16; n++) begin
      rise();
      st = (n == 16) ? chop_pkg::ST_CHARGE : (n >= 11) ? chop_pkg::ST_FAST :
           (tripped && n >= blen) ? chop_pkg::ST_SLOW : chop_pkg::ST_CHARGE;
      check("switches", {hs1, hs2, ls1, ls2, blank},
            {word(st, rev), 1'((n % 16) < blen)});
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (5) @(posedge mclk);
    #1 check("reset state", {hs1, hs2, ls1, ls2, blank}, 5'h01);
    reset_n = 1'b1;
    @(posedge mclk); #1;
    check("first charge", {hs1, hs2, ls1, ls2, blank}, 5'h13);
  endtask
  // No trip: charge straight to fast, period closes in charge
  task automatic t_forward_free();
    period(4, 1'b0);
  endtask
  // Trip held from period start is ignored until blanking ends
  task automatic t_trip_short();
    limit = 8'h01;
    period(4, 1'b1);
  endtask
  // Long blanking, current answering slowly
  task automatic t_trip_long();
    bsel = 1'b1;
    slow = 1'b1;
    period(6, 1'b1);
    bsel = 1'b0;
    slow = 1'b0;
  endtask
  // Mirrored patterns in every state
  task automatic t_reverse();
    rev = 1'b1;
    period(4, 1'b1);
    limit = 8'hff;
    period(4, 1'b0);
    rev = 1'b0;
  endtask
  // Reset in mid-period restarts the count
  task automatic t_midreset();
    repeat (5) rise();
    reset_n = 1'b0;
    #1 check("mid reset", {hs1, hs2, ls1, ls2, blank}, 5'h01);
    @(posedge mclk); #1 reset_n = 1'b1;
    @(posedge mclk); #1;
    period(4, 1'b0);
  endtask
  initial begin
    t_reset();
    t_forward_free();
    t_trip_short();
    t_trip_long();
    t_reverse();
    t_midreset();
    tally_and_finish();
  end
endmodule // chopper_bridge_switch_control_test
